/* fsr_defs.vh */
// register numbers, field positions, reset values and timing counts
// assumes inclusion by bare name from every design file of the block
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH

// register numbers on the host register port
`define FSR_WIN_FIRST        16'h33C2
`define FSR_WIN_LAST         16'h3457
`define FSR_WIN_COUNT        150
`define FSR_NODE_FIRST       16'h3458
`define FSR_NODE_LAST        16'h3497
`define FSR_NODE_COUNT       64
`define FSR_SCAN_STAT        16'h3498

// read answers of the data window
`define FSR_UNMAPPED_VAL     32'hFFFF_FFFF
`define FSR_DEAD_CONN_VAL    32'h0000_0000

// per-node flags, positions inside the upper half (bit 16 -> 0)
`define FSR_NF_POLL_OK       0
`define FSR_NF_STROBE_OK     1
`define FSR_NF_COS_OK        2
`define FSR_NF_EXPL_OK       3
`define FSR_NF_POLL_TO       4
`define FSR_NF_STROBE_TO     5
`define FSR_NF_COS_TO        6
`define FSR_NF_EXPL_TO       7
`define FSR_NF_DEFINED       8
`define FSR_NF_CONFIGURED    9
`define FSR_NF_CONN_FAIL     12
`define FSR_NF_MAP_FAIL      14
`define FSR_NF_NODE_FAIL     15
`define FSR_NF_VALID_MASK    16'hD3FF
`define FSR_NF_TIMEOUT_MASK  16'h00F0
`define FSR_NF_ERROR_MASK    16'hD000

// scanner status bits, lower half
`define FSR_SS_DOWNLOAD      0
`define FSR_SS_STORING       1
`define FSR_SS_VALID_CFG     2
`define FSR_SS_DISABLED      7
`define FSR_SS_CONFIGURED    8
`define FSR_SS_STARTING      9
`define FSR_SS_STOPPING      10
`define FSR_SS_RUNNING       11
`define FSR_SS_NODE_CFG_FAIL 12
`define FSR_SS_FAILED        14
`define FSR_SS_ERROR         15
`define FSR_SS_VALID_MASK    16'hDF87

// reset values
`define FSR_SCAN_CTRL_RST    16'h0000
`define FSR_RETRY_RST        16'h0000

// retry time unit: one second at the 100 MHz module clock
`define FSR_CLK_HZ           100000000
`define FSR_RETRY_UNIT_S     1
`define FSR_SEC_CYCLES       (`FSR_CLK_HZ * `FSR_RETRY_UNIT_S)

`endif

/* fsr_io_window.v */
// mapped i/o data window: map attributes and data words per register
// assumes map entries come from the configuration loader, rx words from the scanner core
`include "fsr_defs.vh"

module fsr_io_window #(
    parameter N  = `FSR_WIN_COUNT,
    parameter IW = 8
) (
    input  wire          ref_clk_i,
    input  wire          sys_rst_i,
    input  wire          map_we_i,
    input  wire [IW-1:0] map_idx_i,
    input  wire          map_valid_i,
    input  wire          map_out_i,
    input  wire [4:0]    map_width_i,
    input  wire [5:0]    map_node_i,
    input  wire          rx_we_i,
    input  wire [IW-1:0] rx_idx_i,
    input  wire [31:0]   rx_data_i,
    input  wire          host_we_i,
    input  wire [IW-1:0] host_idx_i,
    input  wire [31:0]   host_data_i,
    output wire          host_acc_o,
    input  wire [IW-1:0] rd_idx_i,
    output wire          rd_mapped_o,
    output wire          rd_out_o,
    output wire [5:0]    rd_node_o,
    output wire [31:0]   rd_data_o,
    output wire [31:0]   wr_masked_o
);

reg [N-1:0]  map_vld_r;
reg          map_out_r [0:N-1];
reg [4:0]    map_wid_r [0:N-1];
reg [5:0]    map_node_r[0:N-1];
reg [31:0]   data_r    [0:N-1];

// field of width w+1 bits, 1 to 32
function [31:0] fld_mask;
    input [4:0] w;
    begin
        fld_mask = 32'hFFFF_FFFF >> (5'd31 - w);
    end
endfunction

wire host_ok = host_we_i && (host_idx_i < N) && map_vld_r[host_idx_i] && map_out_r[host_idx_i];
wire rx_ok   = rx_we_i && (rx_idx_i < N) && map_vld_r[rx_idx_i] && !map_out_r[rx_idx_i];
wire rd_ok   = (rd_idx_i < N);

assign host_acc_o  = host_ok;
assign wr_masked_o = host_data_i & fld_mask(map_wid_r[host_idx_i]); // RULE2
assign rd_mapped_o = rd_ok && map_vld_r[rd_idx_i];
assign rd_out_o    = map_out_r[rd_idx_i];
assign rd_node_o   = map_node_r[rd_idx_i];
assign rd_data_o   = data_r[rd_idx_i] & fld_mask(map_wid_r[rd_idx_i]); // RULE2

always @(posedge ref_clk_i)
begin
    if (sys_rst_i)
        map_vld_r <= {N{1'b0}};
    else if (map_we_i && map_idx_i < N)
        map_vld_r[map_idx_i] <= map_valid_i;
end

always @(posedge ref_clk_i)
begin
    if (map_we_i && map_idx_i < N)
    begin
        map_out_r[map_idx_i]  <= map_out_i;
        map_wid_r[map_idx_i]  <= map_width_i;
        map_node_r[map_idx_i] <= map_node_i;
    end
    if (host_ok)
        data_r[host_idx_i] <= wr_masked_o;
    if (rx_ok)
        data_r[rx_idx_i] <= rx_data_i; // RULE3
end

endmodule // fsr_io_window

/* fsr_node_table.v */
// per-node status flags, retry time and retry countdown for 64 node addresses
// assumes sec_tick_i is a one-cycle pulse once per second
`include "fsr_defs.vh"

module fsr_node_table #(
    parameter NODES = `FSR_NODE_COUNT
) (
    input  wire             ref_clk_i,
    input  wire             sys_rst_i,
    input  wire             flags_we_i,
    input  wire [5:0]       flags_addr_i,
    input  wire [15:0]      flags_i,
    input  wire             retry_we_i,
    input  wire [5:0]       retry_addr_i,
    input  wire [15:0]      retry_i,
    input  wire             sec_tick_i,
    input  wire [5:0]       rd_addr_i,
    output wire [31:0]      rd_data_o,
    input  wire [5:0]       conn_addr_i,
    output wire             conn_ok_o,
    output wire [NODES-1:0] retry_req_o
);

wire [16*NODES-1:0] flags_v;
wire [16*NODES-1:0] retry_v;

genvar g;
generate
    for (g = 0; g < NODES; g = g + 1)
    begin : g_node
        reg  [15:0] flg_r;
        reg  [15:0] rtm_r;
        reg  [15:0] cnt_r;
        reg         rq_r;
        wire        err = |(flg_r & `FSR_NF_ERROR_MASK);
        wire        wr  = retry_we_i && (retry_addr_i == g);
        always @(posedge ref_clk_i)
        begin
            if (sys_rst_i)
            begin
                flg_r    <= 16'h0000;
                rtm_r    <= `FSR_RETRY_RST;
                cnt_r    <= `FSR_RETRY_RST;
                rq_r     <= 1'b0;
            end
            else
            begin
                rq_r <= 1'b0;
                if (flags_we_i && flags_addr_i == g)
                    flg_r <= flags_i & `FSR_NF_VALID_MASK; // RULE18
                if (wr)
                begin
                    rtm_r <= retry_i; // RULE7
                    cnt_r <= retry_i;
                    if (retry_i == 16'h0000 && err)
                        rq_r <= 1'b1; // RULE7
                end
                else if (sec_tick_i && err && rtm_r != 16'h0000)
                begin
                    if (cnt_r <= 16'h0001)
                    begin
                        rq_r  <= 1'b1;
                        cnt_r <= rtm_r;
                    end
                    else
                        cnt_r <= cnt_r - 16'h0001;
                end
            end
        end
        assign flags_v[16*g +: 16] = flg_r;
        assign retry_v[16*g +: 16] = rtm_r;
        assign retry_req_o[g]      = rq_r;
    end
endgenerate

wire [15:0] cflg = flags_v[16*conn_addr_i +: 16];

assign rd_data_o   = {flags_v[16*rd_addr_i +: 16], retry_v[16*rd_addr_i +: 16]}; // RULE6
assign conn_ok_o   = cflg[`FSR_NF_CONFIGURED]
                     && !(|(cflg & (`FSR_NF_ERROR_MASK | `FSR_NF_TIMEOUT_MASK)));

endmodule // fsr_node_table

/* fsr_regs.v */
// fieldbus scanner status register bank: data window, node status, scanner status
// assumes a host register port addressed by register number and a scanner core
// that supplies map entries, received words, node flags and scanner state
//
// Behaviour
// RULE1: window reads return mapped inputs, window writes drive mapped outputs.
// RULE2: each mapped window field is one to thirty-two bits wide.
// RULE3: a new received message overwrites every mapped input register.
// RULE4: reading an unmapped window register returns minus one.
// RULE5: reading a mapped register with a dead connection returns zero.
// RULE6: node register holds flags in upper half, retry time in lower half.
// RULE7: retry time is in seconds; writing zero retries once at once on error.
// RULE8: node register number is node base plus node address.
// RULE9: node bits 16-19 connection configured, 20-23 connection timeouts.
// RULE10: node bit 24 defined in configuration, bit 25 configured.
// RULE11: node bit 28 connection failure, 30 mapping failure, 31 node failure.
// RULE12: scanner status register reports state in its lower sixteen bits.
// RULE13: scanner bits 0-2 downloading, storing, valid configuration processed.
// RULE14: scanner bits 7-11 disabled, configured, starting, stopping, running.
// RULE15: scanner bit 12 node configuration failed, 14 failed, 15 error.
// RULE16: software must not rely on the reserved status bits.
// RULE17: one node register for each node address zero to sixty-three.
// RULE18: flags are independent bits; software isolates them by masking.
`include "fsr_defs.vh"

module fsr_regs #(
    parameter SEC_CYCLES = `FSR_SEC_CYCLES,
    parameter WIN_N      = `FSR_WIN_COUNT,
    parameter NODES      = `FSR_NODE_COUNT
) (
    input  wire             ref_clk_i,
    input  wire             sys_rst_i,
    // host register port
    input  wire [15:0]      reg_num_i,
    input  wire             reg_rd_i,
    input  wire             reg_wr_i,
    input  wire [31:0]      reg_wdata_i,
    output wire [31:0]      reg_rdata_o,
    output wire             reg_rvalid_o,
    // i/o map configuration
    input  wire             map_we_i,
    input  wire [7:0]       map_idx_i,
    input  wire             map_valid_i,
    input  wire             map_out_i,
    input  wire [4:0]       map_width_i,
    input  wire [5:0]       map_node_address_i,
    // received i/o message words
    input  wire             rx_we_i,
    input  wire [7:0]       rx_idx_i,
    input  wire [31:0]      rx_data_i,
    // mapped output words toward the network
    output wire             out_stb_o,
    output wire [7:0]       out_idx_o,
    output wire [31:0]      out_data_o,
    // node flags from the scanner core and per-node retry requests
    input  wire             node_flags_we_i,
    input  wire [5:0]       node_flags_address_i,
    input  wire [15:0]      node_flags_i,
    output wire [NODES-1:0] retry_req_o,
    // scanner state and host control
    input  wire [15:0]      scan_state_i,
    output wire [15:0]      scan_ctrl_o,
    output wire             scan_ctrl_stb_o
);

////////////////////////////////////////////////////////////////////////////////
// address decode

wire        hit_win  = (reg_num_i >= `FSR_WIN_FIRST) && (reg_num_i <= `FSR_WIN_LAST);
wire        hit_node = (reg_num_i >= `FSR_NODE_FIRST) && (reg_num_i <= `FSR_NODE_LAST);
wire        hit_scan = (reg_num_i == `FSR_SCAN_STAT);
wire [15:0] win_off  = reg_num_i - `FSR_WIN_FIRST;
wire [15:0] node_off = reg_num_i - `FSR_NODE_FIRST;
wire [7:0]  win_idx  = win_off[7:0];
wire [5:0]  node_adr = node_off[5:0]; // RULE8 RULE17

////////////////////////////////////////////////////////////////////////////////
// one-second tick for retry countdown

reg  [31:0] sec_cnt_r;
reg  [31:0] sec_cnt_nxt;
reg         sec_tick_r;
reg         sec_tick_nxt;

always @*
begin
    sec_tick_nxt = 1'b0;
    sec_cnt_nxt  = sec_cnt_r + 32'h0000_0001;
    if (sec_cnt_r >= SEC_CYCLES - 1)
    begin
        sec_cnt_nxt  = 32'h0000_0000;
        sec_tick_nxt = 1'b1;
    end
end

always @(posedge ref_clk_i)
begin
    if (sys_rst_i)
    begin
        sec_cnt_r  <= 32'h0000_0000;
        sec_tick_r <= 1'b0;
    end
    else
    begin
        sec_cnt_r  <= sec_cnt_nxt;
        sec_tick_r <= sec_tick_nxt; // RULE7
    end
end

////////////////////////////////////////////////////////////////////////////////
// data window

wire        win_acc;
wire        win_mapped;
wire        win_is_out;
wire [5:0]  win_node;
wire [31:0] win_data;
wire [31:0] win_wmask;

fsr_io_window #(
    .N  (WIN_N),
    .IW (8)
) u_win (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .map_we_i    (map_we_i),
    .map_idx_i   (map_idx_i),
    .map_valid_i (map_valid_i),
    .map_out_i   (map_out_i),
    .map_width_i (map_width_i),
    .map_node_i  (map_node_address_i),
    .rx_we_i     (rx_we_i),
    .rx_idx_i    (rx_idx_i),
    .rx_data_i   (rx_data_i),
    .host_we_i   (reg_wr_i && hit_win),
    .host_idx_i  (win_idx),
    .host_data_i (reg_wdata_i),
    .host_acc_o  (win_acc),
    .rd_idx_i    (win_idx),
    .rd_mapped_o (win_mapped),
    .rd_out_o    (win_is_out),
    .rd_node_o   (win_node),
    .rd_data_o   (win_data),
    .wr_masked_o (win_wmask)
);

////////////////////////////////////////////////////////////////////////////////
// node table

wire [31:0] node_rd;
wire        conn_ok;

fsr_node_table #(
    .NODES (NODES)
) u_nodes (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .flags_we_i   (node_flags_we_i),
    .flags_addr_i (node_flags_address_i),
    .flags_i      (node_flags_i), // RULE9 RULE10 RULE11
    .retry_we_i   (reg_wr_i && hit_node),
    .retry_addr_i (node_adr),
    .retry_i      (reg_wdata_i[15:0]), // RULE6
    .sec_tick_i   (sec_tick_r),
    .rd_addr_i    (node_adr),
    .rd_data_o    (node_rd),
    .conn_addr_i  (win_node),
    .conn_ok_o    (conn_ok),
    .retry_req_o  (retry_req_o)
);

////////////////////////////////////////////////////////////////////////////////
// mapped output strobe toward the network

reg         out_stb_r;
reg  [7:0]  out_idx_r;
reg  [31:0] out_data_r;

always @(posedge ref_clk_i)
begin
    if (sys_rst_i)
    begin
        out_stb_r  <= 1'b0;
        out_idx_r  <= 8'h00;
        out_data_r <= 32'h0000_0000;
    end
    else
    begin
        out_stb_r <= win_acc; // RULE1
        if (win_acc)
        begin
            out_idx_r  <= win_idx;
            out_data_r <= win_wmask;
        end
    end
end

assign out_stb_o  = out_stb_r;
assign out_idx_o  = out_idx_r;
assign out_data_o = out_data_r;

////////////////////////////////////////////////////////////////////////////////
// scanner status and control

reg  [15:0] scan_ctrl_r;
reg         scan_stb_r;

always @(posedge ref_clk_i)
begin
    if (sys_rst_i)
    begin
        scan_ctrl_r <= `FSR_SCAN_CTRL_RST;
        scan_stb_r  <= 1'b0;
    end
    else
    begin
        scan_stb_r <= reg_wr_i && hit_scan;
        if (reg_wr_i && hit_scan)
            scan_ctrl_r <= reg_wdata_i[15:0];
    end
end

assign scan_ctrl_o     = scan_ctrl_r;
assign scan_ctrl_stb_o = scan_stb_r;

// reserved scanner bits read as zero
wire [31:0] scan_rd = {16'h0000, scan_state_i & `FSR_SS_VALID_MASK}; // RULE12 RULE13 RULE14 RULE15 RULE16

////////////////////////////////////////////////////////////////////////////////
// read path

reg  [31:0] rdata_r;
reg  [31:0] rdata_nxt;
reg         rvalid_r;

always @*
begin
    rdata_nxt = 32'h0000_0000;
    if (hit_win)
    begin
        if (!win_mapped)
            rdata_nxt = `FSR_UNMAPPED_VAL; // RULE4
        else if (!conn_ok)
            rdata_nxt = `FSR_DEAD_CONN_VAL; // RULE5
        else
            rdata_nxt = win_data; // RULE1
    end
    else if (hit_node)
        rdata_nxt = node_rd; // RULE6 RULE18
    else if (hit_scan)
        rdata_nxt = scan_rd;
end

always @(posedge ref_clk_i)
begin
    if (sys_rst_i)
    begin
        rdata_r  <= 32'h0000_0000;
        rvalid_r <= 1'b0;
    end
    else
    begin
        rvalid_r <= reg_rd_i;
        if (reg_rd_i)
            rdata_r <= rdata_nxt;
    end
end

assign reg_rdata_o  = rdata_r;
assign reg_rvalid_o = rvalid_r;

endmodule // fsr_regs

/* fsr_net_model.sv */
// network side model: map loader, received words, node flags, scanner state
// assumes the bench calls its tasks; every change lands at a falling edge
module fsr_net_model (
    input  wire logic  ref_clk_i,
    output logic       map_we_o,
    output logic [7:0] map_idx_o,
    output logic       map_valid_o,
    output logic       map_out_o,
    output logic [4:0] map_width_o,
    output logic [5:0] map_node_o,
    output logic       rx_we_o,
    output logic [7:0] rx_idx_o,
    output logic [31:0] rx_data_o,
    output logic       flags_we_o,
    output logic [5:0] flags_addr_o,
    output logic [15:0] flags_o,
    output logic [15:0] state_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {map_we_o, map_idx_o, map_valid_o, map_out_o, map_width_o, map_node_o} = '0;
        {rx_we_o, rx_idx_o, rx_data_o, flags_we_o, flags_addr_o, flags_o, state_o} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic map_entry(input [7:0] idx, input v, input o, input [4:0] w, input [5:0] n);
        @(negedge ref_clk_i);
        {map_we_o, map_idx_o, map_valid_o, map_out_o, map_width_o, map_node_o} = {1'b1, idx, v, o, w, n};
        @(negedge ref_clk_i);
        map_we_o = 1'b0;
        map_idx_o = ~idx;
    endtask

    // one word of a message per mapped input register
    task automatic rx_word(input [7:0] idx, input [31:0] d);
        @(negedge ref_clk_i);
        {rx_we_o, rx_idx_o, rx_data_o} = {1'b1, idx, d};
        @(negedge ref_clk_i);
        rx_we_o = 1'b0;
        rx_data_o = ~d;
    endtask

    // node address 0..63
    task automatic set_flags(input [5:0] n, input [15:0] f);
        @(negedge ref_clk_i);
        {flags_we_o, flags_addr_o, flags_o} = {1'b1, n, f};
        @(negedge ref_clk_i);
        flags_we_o = 1'b0;
        flags_o = ~f;
    endtask

    task automatic set_state(input [15:0] s);
        @(negedge ref_clk_i);
        state_o = s;
    endtask
endmodule // fsr_net_model

/* fsr_regs_assertions.sv */
// checker for the register bank, watching only its top-level ports
// assumes the bind below; helper state mirrors map and node flag loads
module fsr_regs_chk #(
    parameter NODES = 64
) (
    input wire             ref_clk_i,
    input wire             sys_rst_i,
    input wire [15:0]      reg_num_i,
    input wire             reg_rd_i,
    input wire             reg_wr_i,
    input wire [31:0]      reg_wdata_i,
    input wire [31:0]      reg_rdata_o,
    input wire             reg_rvalid_o,
    input wire             map_we_i,
    input wire [7:0]       map_idx_i,
    input wire             map_valid_i,
    input wire             map_out_i,
    input wire             node_flags_we_i,
    input wire [5:0]       node_flags_address_i,
    input wire [15:0]      node_flags_i,
    input wire [NODES-1:0] retry_req_o,
    input wire [15:0]      scan_state_i,
    input wire [15:0]      scan_ctrl_o,
    input wire             scan_ctrl_stb_o,
    input wire             out_stb_o,
    input wire [7:0]       out_idx_o
);
    logic [149:0] mv_r;
    logic [149:0] mo_r;
    logic [15:0]  nf_r [0:63];
    logic [15:0]  rt_r [0:63];
    wire  [15:0]  wi = reg_num_i - 16'h33C2;
    wire  [15:0]  nd = reg_num_i - 16'h3458;
    wire  [5:0]   ni = nd[5:0];
    wire          in_win = reg_num_i >= 16'h33C2 && reg_num_i <= 16'h3457;
    wire          in_node = reg_num_i >= 16'h3458 && reg_num_i <= 16'h3497;
    wire          win_unm = in_win && !mv_r[wi[7:0]];
    wire          win_outw = in_win && mv_r[wi[7:0]] && mo_r[wi[7:0]];
    wire  [31:0]  node_exp = {nf_r[ni] & 16'hD3FF, rt_r[ni]};
    wire          node_err = |(nf_r[ni] & 16'hD000);

    always @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            mv_r <= '0;
            mo_r <= '0;
            for (int k = 0; k < 64; k++)
            begin
                nf_r[k] <= '0;
                rt_r[k] <= '0;
            end
        end
        else
        begin
            if (map_we_i && map_idx_i < 8'h96)
            begin
                mv_r[map_idx_i] <= map_valid_i;
                mo_r[map_idx_i] <= map_out_i;
            end
            if (node_flags_we_i)
                nf_r[node_flags_address_i] <= node_flags_i;
            if (reg_wr_i && in_node)
                rt_r[ni] <= reg_wdata_i[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read without answer");
    a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without read");
    a_unmapped_minus1: assert property ((reg_rd_i && win_unm) |=> reg_rdata_o == 32'hFFFFFFFF)
        else $error("unmapped window read not all ones");
    a_node_read: assert property ((reg_rd_i && in_node) |=> reg_rdata_o == $past(node_exp))
        else $error("node register read mismatch");
    a_scan_read: assert property ((reg_rd_i && reg_num_i == 16'h3498) |=>
        reg_rdata_o == {16'h0, $past(scan_state_i) & 16'hDF87})
        else $error("scanner status read mismatch");
    a_out_cause: assert property (out_stb_o |-> $past(reg_wr_i && win_outw))
        else $error("output strobe without output write");
    a_out_write: assert property ((reg_wr_i && win_outw) |=> out_stb_o && out_idx_o == $past(wi[7:0]))
        else $error("output write not passed on");
    a_ctrl_write: assert property ((reg_wr_i && reg_num_i == 16'h3498) |=>
        scan_ctrl_stb_o ##0 scan_ctrl_o == $past(reg_wdata_i[15:0]))
        else $error("scanner control write lost");
    a_retry_now: assert property ((reg_wr_i && in_node && reg_wdata_i[15:0] == 16'h0
        && node_err) |=> retry_req_o[$past(ni)])
        else $error("zero retry write on failed node gave no retry");
    a_retry_single: assert property ((retry_req_o != '0) |=> (retry_req_o & $past(retry_req_o)) == '0)
        else $error("retry pulse longer than one cycle");
endmodule // fsr_regs_chk

bind fsr_regs fsr_regs_chk #(.NODES(NODES)) i_chk (.ref_clk_i, .sys_rst_i, .reg_num_i, .reg_rd_i,
    .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .map_we_i, .map_idx_i, .map_valid_i,
    .map_out_i, .node_flags_we_i, .node_flags_address_i, .node_flags_i, .retry_req_o,
    .scan_state_i, .scan_ctrl_o, .scan_ctrl_stb_o, .out_stb_o, .out_idx_o);

/* fsr_regs_tb.sv */
// self-checking bench for the register bank with random and corner stimulus
// assumes a one-second tick shortened to SEC cycles
module fsr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 20;
    logic ref_clk_i, sys_rst_i, reg_rd_i, reg_wr_i;
    logic [15:0] reg_num_i, st;
    logic [31:0] reg_wdata_i, reg_rdata_o, v, d, lfsr_r;
    logic reg_rvalid_o, map_we, map_valid, map_out, rx_we, out_stb_o, fl_we, scan_ctrl_stb_o;
    logic [7:0] map_idx, rx_idx, out_idx_o, idx;
    logic [4:0] map_width, w;
    logic [5:0] map_node, fl_addr, n;
    logic [31:0] rx_data, out_data_o;
    logic [15:0] flags, scan_state, scan_ctrl_o, f;
    logic [63:0] retry_req_o;
    int err_total, compares, c;

    fsr_regs #(.SEC_CYCLES(SEC)) i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .reg_num_i(reg_num_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .map_we_i(map_we),
        .map_idx_i(map_idx), .map_valid_i(map_valid), .map_out_i(map_out), .map_width_i(map_width),
        .map_node_address_i(map_node), .rx_we_i(rx_we), .rx_idx_i(rx_idx), .rx_data_i(rx_data),
        .out_stb_o(out_stb_o), .out_idx_o(out_idx_o), .out_data_o(out_data_o),
        .node_flags_we_i(fl_we), .node_flags_address_i(fl_addr), .node_flags_i(flags),
        .retry_req_o(retry_req_o), .scan_state_i(scan_state), .scan_ctrl_o(scan_ctrl_o),
        .scan_ctrl_stb_o(scan_ctrl_stb_o));
    fsr_net_model i_net (.ref_clk_i(ref_clk_i), .map_we_o(map_we), .map_idx_o(map_idx),
        .map_valid_o(map_valid), .map_out_o(map_out), .map_width_o(map_width),
        .map_node_o(map_node), .rx_we_o(rx_we), .rx_idx_o(rx_idx), .rx_data_o(rx_data),
        .flags_we_o(fl_we), .flags_addr_o(fl_addr), .flags_o(flags), .state_o(scan_state));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction
    function automatic logic [31:0] fmask(input logic [4:0] wd);
        return 32'hFFFFFFFF >> (5'h1F - wd);
    endfunction
    function automatic logic [15:0] nreg(input logic [5:0] a);
        return 16'h3458 + {10'h0, a};
    endfunction
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rd(input logic [15:0] num, output logic [31:0] val);
        @(negedge ref_clk_i);
        reg_rd_i = 1'b1;
        reg_num_i = num;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        check("rvalid", reg_rvalid_o, 32'h1);
        val = reg_rdata_o;
    endtask
    task automatic wr(input logic [15:0] num, input logic [31:0] dat);
        @(negedge ref_clk_i);
        reg_wr_i = 1'b1;
        reg_num_i = num;
        reg_wdata_i = dat;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic wait_retry(input logic [5:0] a);
        c = 0;
        while (retry_req_o[a] !== 1'b1)
        begin
            @(negedge ref_clk_i);
            c++;
            if (c > 4 * SEC)
            begin
                err_total++;
                $display("ERROR retry_wait expected pulse seen none");
                results();
            end
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        {sys_rst_i, reg_rd_i, reg_wr_i, reg_num_i, reg_wdata_i} = {3'h4, 48'h0};
        {err_total, compares, lfsr_r} = {64'h0, 32'h2D};
        repeat (20) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        rd(nreg(6'h05), v);
        check("node_reset", v, 32'h0);
        // scanner status, all ones first
        for (int k = 0; k < 6; k++)
        begin
            st = (k == 0) ? 16'hFFFF : rnd();
            i_net.set_state(st);
            rd(16'h3498, v);
            check("scan_status", v, {16'h0, st & 16'hDF87});
        end
        d = rnd();
        wr(16'h3498, d);
        check("scan_ctrl", {scan_ctrl_stb_o, scan_ctrl_o}, {1'b1, d[15:0]});
        // node registers, both address ends, reserved bits masked off
        for (int k = 0; k < 8; k++)
        begin
            n = (k == 0) ? 6'h00 : (k == 1) ? 6'h3F : rnd();
            f = (k == 0) ? 16'hFFFF : rnd();
            d = rnd() | 32'h1;
            i_net.set_flags(n, f);
            wr(nreg(n), d);
            rd(nreg(n), v);
            check("node_status", v, {f & 16'hD3FF, d[15:0]});
        end
        // unmapped window, both ends
        for (int k = 0; k < 3; k++)
        begin
            idx = (k == 0) ? 8'h00 : (k == 1) ? 8'h95 : rnd() % 150;
            rd(16'h33C2 + {8'h0, idx}, v);
            check("unmapped", v, 32'hFFFFFFFF);
        end
        // mapped inputs, widths one and thirty-two bits among them
        i_net.set_flags(6'h07, 16'h0200);
        for (int k = 0; k < 4; k++)
        begin
            idx = (k == 0) ? 8'h00 : (k == 1) ? 8'h95 : rnd() % 150;
            w = (k == 0) ? 5'h00 : (k == 1) ? 5'h1F : rnd();
            i_net.map_entry(idx, 1'b1, 1'b0, w, 6'h07);
            for (int m = 0; m < 2; m++)
            begin
                d = rnd();
                i_net.rx_word(idx, d);
                rd(16'h33C2 + {8'h0, idx}, v);
                check("window_in", v, d & fmask(w));
            end
        end
        i_net.set_flags(6'h07, 16'h0210);
        rd(16'h33C2 + {8'h0, idx}, v);
        check("dead_conn", v, 32'h0);
        wr(16'h33C2 + {8'h0, idx}, rnd());
        check("input_write", out_stb_o, 32'h0);
        // mapped output
        i_net.set_flags(6'h07, 16'h0200);
        w = rnd();
        i_net.map_entry(8'h00, 1'b1, 1'b1, w, 6'h07);
        d = rnd();
        wr(16'h33C2, d);
        check("window_out", {out_stb_o, out_idx_o, out_data_o}, {9'h100, d & fmask(w)});
        // retry: zero once at once, nonzero every second, none without error
        i_net.set_flags(6'h09, 16'h8000);
        wr(nreg(6'h09), 32'h0);
        check("retry_now", retry_req_o[9], 32'h1);
        @(negedge ref_clk_i);
        check("retry_once", retry_req_o[9], 32'h0);
        wr(nreg(6'h09), 32'h1);
        wait_retry(6'h09);
        @(negedge ref_clk_i);
        wait_retry(6'h09);
        check("retry_period", c + 1, SEC);
        i_net.set_flags(6'h0A, 16'h0200);
        wr(nreg(6'h0A), 32'h0);
        check("retry_no_err", retry_req_o[10], 32'h0);
        results();
    end
endmodule // fsr_regs_tb
